// File: verilog/vic_pkg.sv
/*
  Constants, encodings and state type for the vectored interrupt
  controller. Assumes a single 50 MHz core clock and that every
  consumer imports this package.
*/
package vic_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_SYS   = 16;
  localparam int NUM_IRQ   = 32;
  localparam int NUM_EXC   = 48;
  localparam int PRIO_W    = 3;
  localparam int RANK_W    = 4;
  localparam int EXC_W     = 6;
  localparam int OFS_W     = 10;
  localparam int CNT_W     = 4;
  localparam int STK_DEPTH = 16;
  localparam int STK_AW    = 4;
  localparam int STK_W     = EXC_W + RANK_W;
  localparam int NMI_PINS  = 32;
  localparam int NMI_SEL_W = 5;

  // ==========================================================
  // Exception numbers; the table offset is the number times four
  localparam logic [EXC_W-1:0] EXC_THREAD   = 6'h00;
  localparam logic [EXC_W-1:0] EXC_RESET    = 6'h01;
  localparam logic [EXC_W-1:0] EXC_NMI      = 6'h02;
  localparam logic [EXC_W-1:0] EXC_HARD     = 6'h03;
  localparam logic [EXC_W-1:0] EXC_MEM      = 6'h04;
  localparam logic [EXC_W-1:0] EXC_BUS      = 6'h05;
  localparam logic [EXC_W-1:0] EXC_USAGE    = 6'h06;
  localparam logic [EXC_W-1:0] EXC_SVC      = 6'h0b;
  localparam logic [EXC_W-1:0] EXC_DEBUG    = 6'h0c;
  localparam logic [EXC_W-1:0] EXC_DEFERRED_SERVICE_REQUEST   = 6'h0e;
  localparam logic [EXC_W-1:0] EXC_SYSTEM_TICK  = 6'h0f;
  localparam logic [EXC_W-1:0] EXC_IRQ_BASE = 6'h10;
  localparam logic [OFS_W-1:0] OFS_MSP      = 10'h000;

  // ==========================================================
  // Ranks: lower wins; fixed levels -3,-2,-1 sit below the
  // programmable ones, idle thread level is the weakest
  localparam logic [RANK_W-1:0] RANK_RESET     = 4'h0;
  localparam logic [RANK_W-1:0] RANK_NMI       = 4'h1;
  localparam logic [RANK_W-1:0] RANK_HARD      = 4'h2;
  localparam logic [RANK_W-1:0] RANK_PROG_BASE = 4'h3;
  localparam logic [RANK_W-1:0] RANK_THREAD    = 4'hf;

  // ==========================================================
  // Slots of the system priority bus, three bits each
  localparam int SP_MEM     = 0;
  localparam int SP_BUS     = 1;
  localparam int SP_USAGE   = 2;
  localparam int SP_SVC     = 3;
  localparam int SP_DEBUG   = 4;
  localparam int SP_DEFERRED_SERVICE_REQUEST  = 5;
  localparam int SP_SYSTEM_TICK = 6;
  localparam int NUM_SP     = 7;

  // Fault handler enable bits
  localparam int FE_MEM   = 0;
  localparam int FE_BUS   = 1;
  localparam int FE_USAGE = 2;

  // ==========================================================
  // Per-vector source select codes
  localparam logic [1:0] SRC_FIXED  = 2'h0;
  localparam logic [1:0] SRC_DMA    = 2'h1;
  localparam logic [1:0] SRC_ROUTED = 2'h2;
  localparam logic [1:0] SRC_NONE   = 2'h3;

  // Fixed-function vectors 2 and 26 have no source
  localparam logic [NUM_IRQ-1:0] FIXED_RESERVED_MASK = 32'h0400_0004;
  localparam int DMA_LO_LINES = 16;

  // ==========================================================
  // Cycle counts for automatic state save and restore
  localparam logic [CNT_W-1:0] STACK_CYCLES   = 4'h8;
  localparam logic [CNT_W-1:0] UNSTACK_CYCLES = 4'h8;

  typedef enum logic [2:0] {
    ST_BOOT_SP  = 3'b000,
    ST_BOOT_RST = 3'b001,
    ST_RUN      = 3'b010,
    ST_STACK    = 3'b011,
    ST_ENTRY    = 3'b100,
    ST_UNSTACK  = 3'b101
  } vic_state_e;

endpackage : vic_pkg

// File: verilog/vic_stack_mem.sv
/*
  Small memory holding the preempted execution levels (exception
  number and rank). Read data come out of a register, one cycle
  after the address. Assumes the caller never overflows it.
*/
`timescale 1ns/1ns
module vic_stack_mem
  import vic_pkg::*;
(
  input  wire logic                         clock_i,
  input  wire logic                         wr_en_i,
  input  wire logic [vic_pkg::STK_AW-1:0]   wr_addr_i,
  input  wire logic [vic_pkg::STK_W-1:0]    wr_data_i,
  input  wire logic [vic_pkg::STK_AW-1:0]   rd_addr_i,
  output logic      [vic_pkg::STK_W-1:0]    rd_data_o
);
  import vic_pkg::*;

  logic [STK_W-1:0] mem [STK_DEPTH];

  always_ff @(posedge clock_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : vic_stack_mem

// File: verilog/vic_ctrl.sv
/*
  Vectored interrupt controller core: source selection, pending
  state, priority resolution, nesting, tail-chaining and boot
  vector fetch. Assumes configuration inputs come from logic on
  clock_i; routed lines and NMI pins are asynchronous.
*/
// Notes on behaviour
// - Sixteen system exception slots and thirty-two peripheral requests.
// - Boot fetches stack pointer word at 0, then reset vector at 4.
// - Disabled or masked faults escalate to hard fault at -1, 0x0C.
// - Memory management fault vectors at 0x10 with programmable priority.
// - Bus error on fetch or data access raises bus fault at 0x14.
// - Usage fault vectors at 0x18 with programmable priority.
// - Service call 0x2C, debug 0x30, deferred service 0x38, tick 0x3C.
// - Peripheral request n is exception 16+n, offset four times that.
// - NMI taken from any selected pin or disconnected entirely.
// - Eight peripheral priority levels, changeable at any time.
// - Priority splits into preempting group and subpriority parts.
// - Tail-chaining and late arrival skip restore and re-save.
// - State is saved on entry and restored on exit automatically.
// - Equal priority: lower vector number is serviced first.
// - Each vector picks fixed, DMA or routed source.
// - DMA source: low bus bit n below 16, high bus bit n-16 above.
// - Routed source for vector n is routed bus bit n.
// - Routed path lets any source reach any vector.
// - Fixed map: detect, cache, sleep, ports, I2C, CAN, timers, USB...
`timescale 1ns/1ns
module vic_ctrl
  import vic_pkg::*;
(
  input  wire logic                                   clock_i,
  input  wire logic                                   srst_i,
  input  wire logic [vic_pkg::NUM_IRQ-1:0]            fixed_irq_i,
  input  wire logic [vic_pkg::DMA_LO_LINES-1:0]       dma_term_bus_lo_i,
  input  wire logic [vic_pkg::DMA_LO_LINES-1:0]       dma_term_bus_hi_i,
  input  wire logic [vic_pkg::NUM_IRQ-1:0]            routed_irq_i,
  input  wire logic [2*vic_pkg::NUM_IRQ-1:0]          src_sel_i,
  input  wire logic [vic_pkg::NUM_IRQ-1:0]            irq_enable_i,
  input  wire logic [vic_pkg::PRIO_W*vic_pkg::NUM_IRQ-1:0] irq_prio_i,
  input  wire logic [vic_pkg::PRIO_W*vic_pkg::NUM_SP-1:0]  sys_prio_i,
  input  wire logic [1:0]                             prigroup_i,
  input  wire logic [2:0]                             fault_en_i,
  input  wire logic                                   mem_fault_i,
  input  wire logic                                   bus_fault_i,
  input  wire logic                                   usage_fault_i,
  input  wire logic                                   svc_req_i,
  input  wire logic                                   debug_req_i,
  input  wire logic                                   deferred_service_request_set_i,
  input  wire logic                                   system_tick_i,
  input  wire logic [vic_pkg::NMI_PINS-1:0]           nmi_pins_i,
  input  wire logic                                   nmi_connect_i,
  input  wire logic [vic_pkg::NMI_SEL_W-1:0]          nmi_pin_sel_i,
  input  wire logic                                   vec_ack_i,
  input  wire logic                                   exc_return_i,
  output logic                                        vec_valid_o,
  output logic      [vic_pkg::OFS_W-1:0]              vec_offset_o,
  output logic      [vic_pkg::EXC_W-1:0]              vec_exc_o,
  output logic                                        vec_is_sp_o,
  output logic                                        vec_tail_o,
  output logic                                        stacking_o,
  output logic                                        unstacking_o,
  output logic      [vic_pkg::EXC_W-1:0]              active_exc_o
);
  import vic_pkg::*;

  // ==========================================================
  // Helper functions
  function automatic logic [RANK_W-1:0] exc_rank(
    input int                          n,
    input logic [PRIO_W*NUM_IRQ-1:0]   ip,
    input logic [PRIO_W*NUM_SP-1:0]    sp
  );
    logic [PRIO_W-1:0] p;
    p = '0;
    case (n)
      1:  return RANK_RESET;
      2:  return RANK_NMI;
      3:  return RANK_HARD;
      4:  p = sp[SP_MEM*PRIO_W +: PRIO_W];
      5:  p = sp[SP_BUS*PRIO_W +: PRIO_W];
      6:  p = sp[SP_USAGE*PRIO_W +: PRIO_W];
      11: p = sp[SP_SVC*PRIO_W +: PRIO_W];
      12: p = sp[SP_DEBUG*PRIO_W +: PRIO_W];
      14: p = sp[SP_DEFERRED_SERVICE_REQUEST*PRIO_W +: PRIO_W];
      15: p = sp[SP_SYSTEM_TICK*PRIO_W +: PRIO_W];
      default:
      begin
        if (n < NUM_SYS)
        begin
          return RANK_THREAD;
        end
        p = ip[(n-NUM_SYS)*PRIO_W +: PRIO_W];
      end
    endcase
    return {1'b0, p} + RANK_PROG_BASE;
  endfunction : exc_rank

  // Only the group part decides preemption
  function automatic logic [RANK_W-1:0] grp_key(
    input logic [RANK_W-1:0] r,
    input logic [1:0]        sub
  );
    if (r == RANK_THREAD || r < RANK_PROG_BASE)
    begin
      return r;
    end
    return RANK_PROG_BASE + ((r - RANK_PROG_BASE) >> sub);
  endfunction : grp_key

  function automatic logic [OFS_W-1:0] vec_ofs(input logic [EXC_W-1:0] e);
    return {2'b00, e, 2'b00};
  endfunction : vec_ofs

  // ==========================================================
  // Synchronisers
  logic [NUM_IRQ-1:0]  routed_s1_reg;
  logic [NUM_IRQ-1:0]  routed_s2_reg;
  logic [NMI_PINS-1:0] nmi_s1_reg;
  logic [NMI_PINS-1:0] nmi_s2_reg;
  logic                nmi_q_reg;
  logic                nmi_line;

  always_ff @(posedge clock_i)
  begin
    routed_s1_reg <= routed_irq_i;
    routed_s2_reg <= routed_s1_reg;
    nmi_s1_reg    <= nmi_pins_i;
    nmi_s2_reg    <= nmi_s1_reg;
    nmi_q_reg     <= srst_i ? 1'b0 : nmi_line;
  end

  // Disconnected NMI never fires, whatever the pins do
  assign nmi_line = nmi_connect_i & nmi_s2_reg[nmi_pin_sel_i];

  // ==========================================================
  // Source selection per vector
  logic [NUM_IRQ-1:0] src_line;

  for (genvar g = 0; g < NUM_IRQ; g++)
  begin : g_src
    logic dma_bit;
    if (g < DMA_LO_LINES)
    begin : g_lo
      assign dma_bit = dma_term_bus_lo_i[g];
    end
    else
    begin : g_hi
      assign dma_bit = dma_term_bus_hi_i[g-DMA_LO_LINES];
    end
    always_comb
    begin
      case (src_sel_i[2*g +: 2])
        SRC_FIXED:  src_line[g] = fixed_irq_i[g] &
                                  ~FIXED_RESERVED_MASK[g];
        SRC_DMA:    src_line[g] = dma_bit;
        SRC_ROUTED: src_line[g] = routed_s2_reg[g];
        default:    src_line[g] = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Priority resolution
  logic [NUM_EXC-1:0] pend_reg;
  logic [NUM_EXC-1:0] pend_next;
  logic [RANK_W-1:0]  best_rank;
  logic [EXC_W-1:0]   best_exc;
  logic               win_valid;
  logic [RANK_W-1:0]  cur_rank_reg;
  logic [RANK_W-1:0]  cur_key;

  always_comb
  begin
    logic [RANK_W-1:0] r;
    logic              en;
    r         = '0;
    en        = 1'b0;
    best_rank = RANK_THREAD;
    best_exc  = EXC_THREAD;
    for (int i = 1; i < NUM_EXC; i++)
    begin
      r  = exc_rank(i, irq_prio_i, sys_prio_i);
      en = (i < NUM_SYS) ? 1'b1 : irq_enable_i[i-NUM_SYS];
      // Strict compare keeps the lower number on a tie
      if (pend_reg[i] && en && r < best_rank)
      begin
        best_rank = r;
        best_exc  = EXC_W'(i);
      end
    end
    win_valid = (best_rank != RANK_THREAD);
    cur_key   = grp_key(cur_rank_reg, prigroup_i);
  end

  // ==========================================================
  // Pending state; a new event wins over the clear on entry
  logic [EXC_W-1:0] lat_exc_reg;
  logic             ack;
  logic [NUM_EXC-1:0] set_vec;
  logic [NUM_EXC-1:0] clr_vec;

  function automatic logic masked_fault(
    input logic             en,
    input logic [RANK_W-1:0] key,
    input logic [RANK_W-1:0] ck
  );
    return !en || key >= ck;
  endfunction : masked_fault

  always_comb
  begin
    logic [RANK_W-1:0] km;
    logic [RANK_W-1:0] kb;
    logic [RANK_W-1:0] ku;
    km = grp_key(exc_rank(4, irq_prio_i, sys_prio_i), prigroup_i);
    kb = grp_key(exc_rank(5, irq_prio_i, sys_prio_i), prigroup_i);
    ku = grp_key(exc_rank(6, irq_prio_i, sys_prio_i), prigroup_i);
    set_vec = '0;
    set_vec[NUM_EXC-1:NUM_SYS] = src_line;
    set_vec[EXC_NMI] = nmi_line & ~nmi_q_reg;
    if (mem_fault_i)
    begin
      if (masked_fault(fault_en_i[FE_MEM], km, cur_key))
        set_vec[EXC_HARD] = 1'b1;
      else
        set_vec[EXC_MEM] = 1'b1;
    end
    if (bus_fault_i)
    begin
      if (masked_fault(fault_en_i[FE_BUS], kb, cur_key))
        set_vec[EXC_HARD] = 1'b1;
      else
        set_vec[EXC_BUS] = 1'b1;
    end
    if (usage_fault_i)
    begin
      if (masked_fault(fault_en_i[FE_USAGE], ku, cur_key))
        set_vec[EXC_HARD] = 1'b1;
      else
        set_vec[EXC_USAGE] = 1'b1;
    end
    set_vec[EXC_SVC]     = svc_req_i;
    set_vec[EXC_DEBUG]   = debug_req_i;
    set_vec[EXC_DEFERRED_SERVICE_REQUEST]  = deferred_service_request_set_i;
    set_vec[EXC_SYSTEM_TICK] = system_tick_i;
    clr_vec = '0;
    if (ack)
    begin
      clr_vec[lat_exc_reg] = 1'b1;
    end
    pend_next = (pend_reg & ~clr_vec) | set_vec;
  end

  // ==========================================================
  // Sequencer
  vic_state_e         state_reg;
  vic_state_e         state_next;
  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic [EXC_W-1:0]   cur_exc_reg;
  logic [EXC_W-1:0]   cur_exc_next;
  logic [RANK_W-1:0]  cur_rank_next;
  logic [EXC_W-1:0]   lat_exc_next;
  logic [RANK_W-1:0]  lat_rank_reg;
  logic [RANK_W-1:0]  lat_rank_next;
  logic [STK_AW-1:0]  sp_reg;
  logic [STK_AW-1:0]  sp_next;
  logic               push;
  logic [STK_W-1:0]   stk_rd;
  logic [RANK_W-1:0]  base_key;
  logic [RANK_W-1:0]  best_key;
  logic               vec_valid_next;
  logic               vec_is_sp_next;
  logic               vec_tail_next;
  logic               stacking_next;
  logic               unstacking_next;

  assign ack      = vec_valid_o & vec_ack_i;
  assign best_key = grp_key(best_rank, prigroup_i);
  assign base_key = grp_key(stk_rd[RANK_W-1:0], prigroup_i);

  vic_stack_mem u_stack (
    .clock_i   (clock_i),
    .wr_en_i   (push),
    .wr_addr_i (sp_reg),
    .wr_data_i ({cur_exc_reg, cur_rank_reg}),
    .rd_addr_i (sp_reg - STK_AW'(1)),
    .rd_data_o (stk_rd)
  );

  always_comb
  begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    cur_exc_next    = cur_exc_reg;
    cur_rank_next   = cur_rank_reg;
    lat_exc_next    = lat_exc_reg;
    lat_rank_next   = lat_rank_reg;
    sp_next         = sp_reg;
    push            = 1'b0;
    vec_valid_next  = vec_valid_o;
    vec_is_sp_next  = vec_is_sp_o;
    vec_tail_next   = vec_tail_o;
    stacking_next   = 1'b0;
    unstacking_next = 1'b0;
    case (state_reg)
      ST_BOOT_SP:
      begin
        if (ack)
        begin
          state_next     = ST_BOOT_RST;
          lat_exc_next   = EXC_RESET;
          vec_is_sp_next = 1'b0;
        end
      end
      ST_BOOT_RST:
      begin
        if (ack)
        begin
          state_next     = ST_RUN;
          vec_valid_next = 1'b0;
        end
      end
      ST_RUN:
      begin
        if (exc_return_i && cur_exc_reg != EXC_THREAD)
        begin
          if (win_valid && best_key < base_key)
          begin
            state_next     = ST_ENTRY;
            lat_exc_next   = best_exc;
            lat_rank_next  = best_rank;
            vec_valid_next = 1'b1;
            vec_tail_next  = 1'b1;
          end
          else
          begin
            state_next      = ST_UNSTACK;
            cnt_next        = '0;
            unstacking_next = 1'b1;
          end
        end
        else if (win_valid && best_key < cur_key)
        begin
          state_next    = ST_STACK;
          push          = 1'b1;
          sp_next       = sp_reg + STK_AW'(1);
          cnt_next      = '0;
          lat_exc_next  = best_exc;
          lat_rank_next = best_rank;
          stacking_next = 1'b1;
        end
      end
      ST_STACK:
      begin
        stacking_next = 1'b1;
        // A stronger request during the save takes over the entry
        if (win_valid &&
            best_key < grp_key(lat_rank_reg, prigroup_i))
        begin
          lat_exc_next  = best_exc;
          lat_rank_next = best_rank;
        end
        cnt_next = cnt_reg + CNT_W'(1);
        if (cnt_reg == STACK_CYCLES - CNT_W'(1))
        begin
          state_next     = ST_ENTRY;
          stacking_next  = 1'b0;
          vec_valid_next = 1'b1;
          vec_tail_next  = 1'b0;
        end
      end
      ST_ENTRY:
      begin
        if (ack)
        begin
          state_next     = ST_RUN;
          cur_exc_next   = lat_exc_reg;
          cur_rank_next  = lat_rank_reg;
          vec_valid_next = 1'b0;
          vec_tail_next  = 1'b0;
        end
      end
      ST_UNSTACK:
      begin
        unstacking_next = 1'b1;
        cnt_next        = cnt_reg + CNT_W'(1);
        if (cnt_reg == UNSTACK_CYCLES - CNT_W'(1))
        begin
          state_next      = ST_RUN;
          unstacking_next = 1'b0;
          cur_exc_next    = stk_rd[STK_W-1:RANK_W];
          cur_rank_next   = stk_rd[RANK_W-1:0];
          sp_next         = sp_reg - STK_AW'(1);
        end
      end
      default:
      begin
        state_next = ST_BOOT_SP;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_reg    <= ST_BOOT_SP;
      pend_reg     <= '0;
      cnt_reg      <= '0;
      cur_exc_reg  <= EXC_THREAD;
      cur_rank_reg <= RANK_THREAD;
      lat_exc_reg  <= EXC_THREAD;
      lat_rank_reg <= RANK_RESET;
      sp_reg       <= '0;
      vec_valid_o  <= 1'b1;
      vec_offset_o <= OFS_MSP;
      vec_exc_o    <= EXC_THREAD;
      vec_is_sp_o  <= 1'b1;
      vec_tail_o   <= 1'b0;
      stacking_o   <= 1'b0;
      unstacking_o <= 1'b0;
      active_exc_o <= EXC_THREAD;
    end
    else
    begin
      state_reg    <= state_next;
      pend_reg     <= pend_next;
      cnt_reg      <= cnt_next;
      cur_exc_reg  <= cur_exc_next;
      cur_rank_reg <= cur_rank_next;
      lat_exc_reg  <= lat_exc_next;
      lat_rank_reg <= lat_rank_next;
      sp_reg       <= sp_next;
      vec_valid_o  <= vec_valid_next;
      vec_offset_o <= vec_is_sp_next ? OFS_MSP : vec_ofs(lat_exc_next);
      vec_exc_o    <= vec_is_sp_next ? EXC_THREAD : lat_exc_next;
      vec_is_sp_o  <= vec_is_sp_next;
      vec_tail_o   <= vec_tail_next;
      stacking_o   <= stacking_next;
      unstacking_o <= unstacking_next;
      active_exc_o <= cur_exc_next;
    end
  end

endmodule : vic_ctrl

// File: testbench/vic_ctrl_monitor.sv
/*
  Checker for the vic_ctrl vector handshake and save/restore.
  Assumes it is bound to vic_ctrl with matching port names.
*/
`timescale 1ns/1ns
module vic_ctrl_monitor
  import vic_pkg::*;
(
  input wire logic                      clock_i,
  input wire logic                      srst_i,
  input wire logic                      vec_ack_i,
  input wire logic                      exc_return_i,
  input wire logic                      vec_valid_o,
  input wire logic [vic_pkg::OFS_W-1:0] vec_offset_o,
  input wire logic [vic_pkg::EXC_W-1:0] vec_exc_o,
  input wire logic                      vec_is_sp_o,
  input wire logic                      vec_tail_o,
  input wire logic                      stacking_o,
  input wire logic                      unstacking_o
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  logic take;
  assign take = vec_valid_o && vec_ack_i;
  property p_boot;
    $fell(srst_i) |-> vec_valid_o && vec_is_sp_o && vec_offset_o == 0;
  endproperty
  a_boot: assert property (p_boot) else $error("boot word");
  property p_rst;
    take && vec_is_sp_o |=> vec_valid_o && vec_exc_o == 6'h01;
  endproperty
  a_rst: assert property (p_rst) else $error("reset vector");
  property p_ofs;
    vec_valid_o && !vec_is_sp_o |-> vec_offset_o == {vec_exc_o, 2'b00};
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset");
  property p_clr;
    take && !vec_is_sp_o |=> !vec_valid_o;
  endproperty
  a_clr: assert property (p_clr) else $error("valid after ack");
  property p_stk;
    $rose(stacking_o) |-> stacking_o[*8] ##1 !stacking_o;
  endproperty
  a_stk: assert property (p_stk) else $error("save length");
  property p_ustk;
    $rose(unstacking_o) |-> unstacking_o[*8] ##1 !unstacking_o;
  endproperty
  a_ustk: assert property (p_ustk) else $error("restore length");
  property p_entry;
    $rose(vec_valid_o) && !vec_tail_o |-> $past(stacking_o);
  endproperty
  a_entry: assert property (p_entry) else $error("no save");
  property p_tail;
    $rose(vec_valid_o) && vec_tail_o |-> $past(exc_return_i);
  endproperty
  a_tail: assert property (p_tail) else $error("tail chain");
  c_tail: cover property ($rose(vec_valid_o) && vec_tail_o);
  c_stk: cover property ($rose(stacking_o));
  c_ustk: cover property ($rose(unstacking_o));
endmodule : vic_ctrl_monitor

bind vic_ctrl vic_ctrl_monitor u_mon (.*);

// File: testbench/vic_core_model.sv
/*
  Core side model: takes each offered vector at once or after
  a delay. Assumes vec_valid_i comes from vic_ctrl.
*/
`timescale 1ns/1ns
module vic_core_model (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic vec_valid_i,
  input  wire logic slow_i,
  output logic      vec_ack_o
);
  logic [2:0] wait_cnt;
  // Ack is held until the edge that takes it, then dropped
  // Only offsets are seen; handler words carry bit 0 set
  always @(posedge clock_i)
  begin
    if (srst_i || !vec_valid_i || vec_ack_o)
    begin
      wait_cnt <= 3'h0;
      vec_ack_o <= 1'b0;
    end
    else if (!slow_i || wait_cnt == 3'h5)
      vec_ack_o <= 1'b1;
    else
      wait_cnt <= wait_cnt + 3'h1;
  end
endmodule : vic_core_model

// File: testbench/testbench.sv
/*
  Self-checking bench for vic_ctrl: boot, sources, priority,
  system events and NMI. Assumes vic_core_model acks vectors.
*/
`timescale 1ns/1ns
`define CHK(nm, e, s) \
  begin \
    samples_checked++; \
    if ((e) !== (s)) \
    begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, e, s); \
    end \
  end
module testbench;
  import vic_pkg::*;
  logic        clock_i, srst_i, nmi_on, ret, ack, slow;
  logic        vld, vsp, vtl, stk, ustk;
  logic [31:0] fix, rte, pins, ien;
  logic [15:0] dlo, dhi;
  logic [63:0] sel;
  logic [95:0] ip;
  logic [6:0]  ev;
  logic [4:0]  nsel;
  logic [1:0]  pg;
  logic [2:0]  fen;
  logic [9:0]  voff;
  logic [5:0]  vexc, act;
  logic [17:0] cur;
  logic [17:0] exp_q[$];
  logic [5:0]  sys_exc[7] = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c,
                              6'h0e, 6'h0f};
  int          fails, samples_checked, takes, n;
  vic_ctrl uut (.clock_i(clock_i), .srst_i(srst_i), .fixed_irq_i(fix),
    .dma_term_bus_lo_i(dlo), .dma_term_bus_hi_i(dhi),
    .routed_irq_i(rte), .src_sel_i(sel), .irq_enable_i(ien),
    .irq_prio_i(ip), .sys_prio_i(21'h0), .prigroup_i(pg),
    .fault_en_i(fen), .mem_fault_i(ev[0]), .bus_fault_i(ev[1]),
    .usage_fault_i(ev[2]), .svc_req_i(ev[3]), .debug_req_i(ev[4]),
    .deferred_service_request_set_i(ev[5]), .system_tick_i(ev[6]), .nmi_pins_i(pins),
    .nmi_connect_i(nmi_on), .nmi_pin_sel_i(nsel), .vec_ack_i(ack),
    .exc_return_i(ret), .vec_valid_o(vld), .vec_offset_o(voff),
    .vec_exc_o(vexc), .vec_is_sp_o(vsp), .vec_tail_o(vtl),
    .stacking_o(stk), .unstacking_o(ustk), .active_exc_o(act));
  vic_core_model core (.clock_i(clock_i), .srst_i(srst_i),
    .vec_valid_i(vld), .slow_i(slow), .vec_ack_o(ack));
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // ==========================================================
  // Each taken vector is matched against the oldest note
  always @(posedge clock_i)
  begin
    if (srst_i === 1'b0 && vld === 1'b1 && ack === 1'b1)
    begin
      takes++;
      cur = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3ffff;
      `CHK("vector", cur, {vsp, vtl, vexc, voff})
    end
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Waits for a take count, and optionally for thread level
  task automatic waitb(input int goal, input bit idle);
    bit busy;
    for (int i = 0; i < 90; i++)
    begin
      busy = takes < goal || (idle && !(act === 6'h00 &&
             {vld, stk, ustk} === 3'b000));
      if (busy)
      begin
        @(posedge clock_i);
        #1;
      end
    end
    if (busy)
    begin
      fails++;
      final_report();
    end
  endtask : waitb
  task automatic take(input logic [5:0] exc, input logic tail);
    exp_q.push_back({1'b0, tail, exc, 2'b00, exc, 2'b00});
    waitb(takes + 1, 1'b0);
    @(posedge clock_i);
    #1 `CHK("active", exc, act)
    @(posedge clock_i);
    ret <= 1'b1;
    @(posedge clock_i);
    ret <= 1'b0;
  endtask : take
  task automatic fire(input logic [1:0] s, input logic [31:0] hit,
                      input logic [31:0] miss);
    @(posedge clock_i);
    sel <= {32{s}};
    fix <= (s == SRC_FIXED) ? hit : miss;
    {dhi, dlo} <= (s == SRC_DMA) ? hit : miss;
    rte <= (s == SRC_ROUTED) ? hit : miss;
    @(posedge clock_i);
    {fix, dhi, dlo, rte} <= '0;
  endtask : fire
  initial
  begin
    {srst_i, nmi_on, ret, slow, fix, rte, pins} = {1'b1, 99'h0};
    {dlo, dhi, sel, ip, ev, nsel, fen, pg} = '0;
    ien = '1;
    void'($urandom(10));
    exp_q.push_back(18'h20000);
    exp_q.push_back({2'b00, 6'h01, 10'h004});
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    waitb(2, 1'b1);
    $display("boot done");
    for (int k = 0; k < 12; k++)
    begin
      n = $urandom % 32;
      if (k % 3 == 0 && (n == 2 || n == 26))
        n++;
      slow <= k[0];
      fire(2'(k % 3), 32'h1 << n, 32'h1 << ((n + 5) % 32));
      take(6'(16 + n), 1'b0);
      waitb(0, 1'b1);
    end
    // Disabled vector keeps its pending bit; reserved and unselected stay off
    ien <= 32'hffff_fffe;
    fire(SRC_FIXED, 32'h0400_0005, '0);
    fire(SRC_NONE, '0, '1);
    repeat (12) @(posedge clock_i);
    #1 `CHK("held off", 8'h00, {vld, stk, act})
    ien <= '1;
    take(6'h10, 1'b0);
    waitb(0, 1'b1);
    $display("sources done");
    ip[9 +: 3] <= 3'h5;
    ip[27 +: 3] <= 3'h5;
    fire(SRC_FIXED, 32'h0000_0208, '0);
    take(6'h13, 1'b0);
    take(6'h19, 1'b1);
    waitb(0, 1'b1);
    @(posedge clock_i);
    ip[27 +: 3] <= 3'h1;
    fire(SRC_FIXED, 32'h0000_0208, '0);
    take(6'h19, 1'b0);
    take(6'h13, 1'b1);
    waitb(0, 1'b1);
    $display("priority done");
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 7; i++)
      begin
        @(posedge clock_i);
        fen <= {3{p[0]}};
        ev <= 7'h1 << i;
        @(posedge clock_i);
        ev <= '0;
        n = (i < 3 && p == 0) ? 3 : int'(sys_exc[i]);
        take(6'(n), 1'b0);
        waitb(0, 1'b1);
      end
    // One group: an enabled fault cannot preempt, so it escalates
    pg <= 2'h3;
    ip[2:0] <= 3'h7;
    exp_q.push_back({2'b00, 6'h10, 10'h040});
    fire(SRC_FIXED, 32'h1, '0);
    waitb(takes + 1, 1'b0);
    ev <= 7'h1;
    @(posedge clock_i);
    ev <= '0;
    take(6'h03, 1'b0);
    repeat (10) @(posedge clock_i);
    ret <= 1'b1;
    @(posedge clock_i);
    {ret, pg} <= '0;
    waitb(0, 1'b1);
    $display("system events done");
    @(posedge clock_i);
    nsel <= 5'($urandom % 32);
    nmi_on <= 1'b1;
    @(posedge clock_i);
    pins <= 32'h1 << nsel;
    take(6'h02, 1'b0);
    waitb(0, 1'b1);
    @(posedge clock_i);
    {pins, nmi_on} <= '0;
    @(posedge clock_i);
    pins <= '1;
    repeat (20) @(posedge clock_i);
    #1 `CHK("nmi off", 8'h00, {vld, stk, act})
    $display("nmi done");
    final_report();
  end
endmodule : testbench
